// [rtl/hps_change_flag.sv]
// Module: one sticky change flag, set wins over write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module hps_change_flag (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule // hps_change_flag
`default_nettype wire

// [rtl/hps_mode_filter.sv]
// Module: keeps the reported operation mode to legal codes only
`timescale 1ns/100ps
`default_nettype none
module hps_mode_filter
	import hps_pkg::*;
(
	input  wire logic [2:0] raw_i,
	input  wire hps_mode_t  held_i,
	output hps_mode_t       mode_o
);
	// Reserved codes 5..7 are never reported; the last legal mode stays
	always_comb begin
		if (raw_i <= 3'h4) begin
			mode_o = hps_mode_t'(raw_i);
		end else begin
			mode_o = held_i;
		end
	end
endmodule // hps_mode_filter
`default_nettype wire

// [rtl/hps_pkg.sv]
// Package: register map, field layout and types of the port power status word
package hps_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] HPS_STATUS_OFS  = 8'h00;
	localparam logic [7:0] HPS_INT_MASK_OFS = 8'h04;
	localparam logic [7:0] HPS_INT_STAT_OFS = 8'h08;
	localparam logic [7:0] HPS_CTRL_OFS    = 8'h0C;

	// Field positions in the status word
	localparam int HPS_CHG_SUPPLY_BIT = 1;
	localparam int HPS_CHG_MODE_BIT   = 2;
	localparam int HPS_CHG_CABLE_BIT  = 7;
	localparam int HPS_CHG_SWAP_BIT   = 12;
	localparam int HPS_CHG_VENDOR_MSG_BIT = 13;
	localparam int HPS_CHG_RSVD_BIT   = 14;
	localparam int HPS_CHG_ERR_BIT    = 15;
	localparam int HPS_SUPPLY_BIT     = 16;
	localparam int HPS_MODE_LSB       = 17;
	localparam int HPS_CABLE_BIT      = 20;
	localparam int HPS_ROLE_BIT       = 22;

	// Mask of change bits this block owns
	localparam logic [15:0] HPS_CHG_MASK = 16'hB086;

	// Reset values
	localparam logic [15:0] HPS_CHG_RST  = 16'h0000;
	localparam logic [15:0] HPS_MASK_RST = 16'h0000;

	// Port operation modes
	typedef enum logic [2:0] {
		HPS_MODE_NONE   = 3'b000,
		HPS_MODE_LEGACY = 3'b001,
		HPS_MODE_CHARGING = 3'b010,
		HPS_MODE_PD     = 3'b011,
		HPS_MODE_TYPEC  = 3'b100
	} hps_mode_t;

	// Live port state delivered by the port policy logic
	typedef struct packed {
		logic      ext_powered;
		hps_mode_t mode;
		logic      cable;
		logic      provider;
	} hps_port_t;

	// Port events, one-cycle pulses
	typedef struct packed {
		logic swap_done;
		logic vendor_msg_rx;
		logic error;
	} hps_evt_t;

endpackage : hps_pkg

// [rtl/hps_status_word.sv]
// Module: port power status word with Wishbone slave and interrupt
`timescale 1ns/100ps
`default_nettype none
module hps_status_word
	import hps_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        ext_powered_i,
	input  wire logic [2:0]  mode_i,
	input  wire logic        cable_i,
	input  wire logic        provider_i,
	input  wire hps_evt_t    evt_i,
	output logic             irq_o
);
	hps_port_t   port_reg;
	hps_port_t   port_next;
	hps_mode_t   mode_ok;
	logic [15:0] chg_set;
	logic [15:0] chg_clr;
	logic [15:0] chg_flags;
	logic [15:0] mask_reg;
	logic [31:0] status_word;
	logic        req;
	logic        wr;

	assign req = cyc_i && stb_i && !ack_o;
	// Writes land on the edge at which the master samples ack high
	assign wr  = cyc_i && stb_i && we_i && ack_o;

	hps_mode_filter i_hps_mode_filter (
		.raw_i  (mode_i),
		.held_i (port_reg.mode),
		.mode_o (mode_ok)
	);

	// Live port state, sampled into the word
	always_comb begin
		port_next.ext_powered = ext_powered_i;
		port_next.mode        = mode_ok;
		port_next.cable       = cable_i;
		port_next.provider    = provider_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_reg <= '0;
		end else begin
			port_reg <= port_next;
		end
	end

	// Change events
	always_comb begin
		chg_set = 16'h0000;
		chg_set[HPS_CHG_SUPPLY_BIT] =
			port_next.ext_powered != port_reg.ext_powered;
		chg_set[HPS_CHG_MODE_BIT] =
			port_next.mode != port_reg.mode;
		chg_set[HPS_CHG_CABLE_BIT] =
			port_next.cable != port_reg.cable;
		chg_set[HPS_CHG_SWAP_BIT] = evt_i.swap_done;
		chg_set[HPS_CHG_VENDOR_MSG_BIT] = evt_i.vendor_msg_rx;
		chg_set[HPS_CHG_ERR_BIT]  = evt_i.error;
	end

	// Write one to clear on the low status half
	always_comb begin
		chg_clr = 16'h0000;
		if (wr && adr_i == HPS_STATUS_OFS) begin
			if (sel_i[0]) begin
				chg_clr[7:0] = dat_i[7:0];
			end
			if (sel_i[1]) begin
				chg_clr[15:8] = dat_i[15:8];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_chg
			if (HPS_CHG_MASK[gi]) begin : g_on
				hps_change_flag i_hps_change_flag (
					.clk_i  (clk_i),
					.rst_i  (rst_i),
					.set_i  (chg_set[gi]),
					.clr_i  (chg_clr[gi]),
					.flag_o (chg_flags[gi])
				);
			end else begin : g_off
				assign chg_flags[gi] = 1'b0;
			end
		end
	endgenerate

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[15:0] = chg_flags;
		status_word[HPS_SUPPLY_BIT] = port_reg.ext_powered;
		status_word[HPS_MODE_LSB +: 3] = port_reg.mode;
		status_word[HPS_CABLE_BIT] = port_reg.cable;
		status_word[HPS_ROLE_BIT] = port_reg.provider;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= HPS_MASK_RST;
		end else if (wr && adr_i == HPS_INT_MASK_OFS) begin
			if (sel_i[0]) begin
				mask_reg[7:0] <= dat_i[7:0] & HPS_CHG_MASK[7:0];
			end
			if (sel_i[1]) begin
				mask_reg[15:8] <= dat_i[15:8] & HPS_CHG_MASK[15:8];
			end
		end
	end

	// Single-cycle acknowledge, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			if (req && !we_i) begin
				unique case (adr_i)
					HPS_STATUS_OFS:   dat_o <= status_word;
					HPS_INT_MASK_OFS: dat_o <= {16'h0000, mask_reg};
					HPS_INT_STAT_OFS: dat_o <= {16'h0000, chg_flags & mask_reg};
					default:          dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((chg_flags | chg_set) & mask_reg & ~chg_clr |
				chg_set & mask_reg);
		end
	end

endmodule // hps_status_word
`default_nettype wire

// [sim/hps_host_model.sv]
// Host register master issuing classic Wishbone cycles
`timescale 1ns/100ps
`default_nettype none
module hps_host_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [3:0]       sel_o,
	output logic [7:0]       adr_o,
	output logic [31:0]      dat_o
);
	initial begin
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
	end
	// Request held until ack is sampled; released data is inverted
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic t);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, 4'h3, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 16);
		q = dat_i;
		t = (ack_i !== 1'b1);
		{cyc_o, stb_o, we_o, sel_o} <= '0;
		dat_o <= ~d;
	endtask
endmodule // hps_host_model
`default_nettype wire

// [sim/hps_status_word_bench.sv]
// Bench for the port power status word
`timescale 1ns/100ps
`default_nettype none
module hps_status_word_bench import hps_pkg::*;;
	logic clk = 0, rst = 1, cyc, stb, we, ack, ext = 0, cab = 0, prv = 0, irq;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [2:0]  mode = 0;
	logic [31:0] di, dq;
	hps_evt_t    evt = '0;
	int          mismatches = 0, compares = 0;
	logic [15:0] b [3] = '{16'h8000, 16'h2000, 16'h1000};
	always #20 clk = ~clk;
	hps_host_model i_hps_host_model (.clk_i(clk), .ack_i(ack), .dat_i(dq),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr),
		.dat_o(di));
	hps_status_word i_hps_status_word (.clk_i(clk), .rst_i(rst),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(di), .dat_o(dq), .ack_o(ack), .ext_powered_i(ext),
		.mode_i(mode), .cable_i(cab), .provider_i(prv), .evt_i(evt),
		.irq_o(irq));
	task automatic give_verdict;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One bus cycle; reads are compared with e
	task automatic acc(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] e);
		logic [31:0] q;
		logic        t;
		i_hps_host_model.xfer(w, a, d, q, t);
		if (t) begin
			mismatches++;
			give_verdict();
		end
		if (!w)
			chk(q, e);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 20; i += 4) acc(0, 8'(i), 0, 0);
		$display("test reset done");
		{ext, mode, cab, prv} <= 6'b1_011_11;
		repeat (2) @(posedge clk);
		acc(0, 8'h00, 0, 32'h0057_0086);
		acc(1, 8'h00, 32'h0000_FFFF, 0);
		mode <= 3'd5;
		repeat (2) @(posedge clk);
		acc(0, 8'h00, 0, 32'h0057_0000);
		for (int m = 4; m >= 0; m--) begin
			{ext, mode} <= {1'b0, 3'(m)};
			repeat (2) @(posedge clk);
			acc(0, 8'h00, 0, 32'h0050_0004 | (m << 17) | (m == 4) << 1);
			acc(1, 8'h00, 32'h0000_FFFF, 0);
		end
		$display("test fields done");
		acc(1, 8'h04, 32'h0000_B086, 0);
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				acc(1, 8'h04, 0, 0);
			evt <= 3'(1 << (i % 3));
			@(posedge clk);
			evt <= '0;
			acc(0, 8'h00, 0, 32'h0050_0000 | b[i % 3]);
			acc(0, 8'h08, 0, i < 3 ? b[i] : 0);
			chk(irq, i < 3);
			acc(1, 8'h08, 32'h0000_FFFF, 0);
			acc(1, 8'h00, b[i % 3], 0);
			@(posedge clk);
			chk(irq, 0);
		end
		// Event and write-one-to-clear on the same edge: the set wins
		fork
			acc(1, 8'h00, 32'h0000_8000, 0);
			begin
				repeat (2) @(posedge clk);
				evt <= 3'b001;
				@(posedge clk);
				evt <= '0;
			end
		join
		acc(0, 8'h00, 0, 32'h0050_8000);
		acc(1, 8'h00, 32'h0000_8000, 0);
		acc(0, 8'h00, 0, 32'h0050_0000);
		$display("test events done");
		give_verdict();
	end
endmodule // hps_status_word_bench
`default_nettype wire

// [sim/hps_status_word_checker.sv]
// Checker for the port power status word
`timescale 1ns/100ps
`default_nettype none
module hps_status_word_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        ext_powered_i,
	input wire logic [2:0]  mode_i,
	input wire logic        cable_i,
	input wire logic        provider_i,
	input wire logic        irq_o
);
	logic        rd_q;
	logic [17:0] ph;
	logic        calm;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Port inputs of the last three edges, for reads of a settled word
	always_ff @(posedge clk_i) begin
		rd_q <= cyc_i && stb_i && !we_i && adr_i == 8'h00;
		ph <= {ph[11:0], ext_powered_i, mode_i, cable_i, provider_i};
	end
	assign calm = ph[17:12] == ph[5:0] && ph[11:6] == ph[5:0];
	chk_ack_answer: assert property (
		cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	chk_rsvd_zero: assert property (
		ack_o && rd_q |-> !dat_o[14]) else $error("bit 14 set");
	chk_supply_copy: assert property (
		ack_o && rd_q && calm |-> dat_o[16] == ph[5]) else $error("supply");
	chk_mode_legal: assert property (
		ack_o && rd_q |-> dat_o[19:17] < 3'd5) else $error("mode code");
	chk_mode_copy: assert property (
		ack_o && rd_q && calm && ph[4:2] < 3'd5 |-> dat_o[19:17] == ph[4:2])
		else $error("mode");
	chk_cable_copy: assert property (
		ack_o && rd_q && calm |-> dat_o[20] == ph[1]) else $error("cable");
	chk_role_copy: assert property (
		ack_o && rd_q && calm |-> dat_o[22] == ph[0]) else $error("role");
	chk_irq_sticky: assert property (
		irq_o && !(cyc_i && stb_i && we_i) |=> irq_o) else $error("irq");
endmodule // hps_status_word_checker
bind hps_status_word hps_status_word_checker i_hps_status_word_checker (
	.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
	.ext_powered_i, .mode_i, .cable_i, .provider_i, .irq_o);
`default_nettype wire
